// File: csd_acc_drv.sv
// Far side: external master and internal requesters
module csd_acc_drv
   import csd_pkg::*;
(
   // Clock and bench command
   input wire logic CLK,
   input wire logic go,
   input wire logic ext,
   input wire logic [1:0] rq,
   input wire logic [CSD_AW-1:0] ad,
   input wire logic [2:0] fc,
   // Lines into the decoder
   output logic ACC_VALID = 1'b0,
   output logic [CSD_AW-1:0] ACC_ADDR = 24'h00_0000,
   output logic [2:0] ACCESS_SPACE_CODE = 3'h0,
   output logic ACC_EXTERNAL = 1'b0,
   output logic [1:0] ACC_REQ = 2'h0,
   output logic AUTOVECTOR_REQUEST_N = 1'b1
);
   // Idle address flips so a stale value never decodes by luck
   always @(posedge CLK) begin
      ACC_VALID <= go;
      ACC_ADDR <= go ? ad : ~ACC_ADDR;
      ACCESS_SPACE_CODE <= go ? fc : 3'h0;
      ACC_EXTERNAL <= ext;
      ACC_REQ <= rq;
      AUTOVECTOR_REQUEST_N <= 1'b1;
   end
endmodule : csd_acc_drv

// File: csd_checker.sv
// Port-level checks on the select decoder
module csd_checker
   import csd_pkg::*;
(
   // Clock and reset
   input wire logic CLK,
   input wire logic SRST,
   // Bus response
   input wire logic HREADYOUT,
   input wire logic HRESP,
   // Access lines
   input wire logic ACC_VALID,
   input wire logic [2:0] ACCESS_SPACE_CODE,
   input wire logic ACC_EXTERNAL,
   input wire logic [1:0] ACC_REQ,
   // Decode results
   input wire logic [CSD_NUM_CS-1:0] CS_N,
   input wire logic IACK_CYCLE,
   input wire logic [2:0] REQ_SPACE_CODE,
   input wire logic REQ_BYTE_READ
);
   default clocking @(posedge CLK); endclocking
   default disable iff (SRST);
   // Access kinds seen at the inputs
   wire logic ext_iack = ACC_VALID && ACC_EXTERNAL && ACCESS_SPACE_CODE == CSD_FC_IACK;
   wire logic refresh = ACC_VALID && !ACC_EXTERNAL && ACC_REQ == 2'(CSD_REQ_REFRESH);
   // Outputs lag their cause by exactly one edge
   iack_neg_a: assert property (ext_iack |=> &CS_N && IACK_CYCLE)
      else $error("select or flag wrong in iack cycle");
   iack_only_a: assert property (!ext_iack |=> !IACK_CYCLE) else $error("stray iack flag");
   idle_neg_a: assert property (!ACC_VALID |=> &CS_N) else $error("select with no access");
   code_block_a: assert property (REQ_SPACE_CODE == CSD_FC_IACK |-> &CS_N)
      else $error("select with code seven");
   ext_code_a: assert property (ACC_VALID && ACC_EXTERNAL |=> REQ_SPACE_CODE == $past(ACCESS_SPACE_CODE))
      else $error("external code not passed");
   byte_read_a: assert property (refresh |=> REQ_BYTE_READ) else $error("refresh not byte read");
   no_byte_a: assert property (ACC_VALID && !refresh |=> !REQ_BYTE_READ) else $error("stray byte read");
   bus_okay_a: assert property (HREADYOUT && !HRESP) else $error("bus not ready or not okay");
   // Main scenarios reached
   cover property (ext_iack);
   cover property (refresh);
   cover property (ACC_VALID ##1 !CS_N[0]);
endmodule : csd_checker

bind csd_top csd_checker chk_u (.*);

// File: csd_match.sv
// One select comparator
module csd_match
   import csd_pkg::*;
(
   // Programming
   input wire logic [CSD_AW-1:0] base,
   input wire logic [CSD_AW-1:0] mask,
   // Access
   input wire logic [CSD_AW-1:0] addr,
   output logic hit
);
   // Only mask-enabled bits take part; holes in the mask alias the select
   assign hit = ((addr ^ base) & mask) == '0; // [R01]
endmodule : csd_match

// File: csd_pkg.sv
// Notes on behaviour
// R01 - Compare only address bits enabled by mask
// R02 - DMA or refresh space code 111 blocks selects
// R03 - External space code 111 is interrupt acknowledge
// R04 - External master drives space code not 111
// R05 - No select inside reserved register window
// R06 - Base register on chip, software writes it
// R07 - Refresh access is one byte read
// R08 - Requester space codes undefined, software loads them
// R09 - Autovector replaces transfer acknowledge, else high
// R10 - Select needs address match and legal code
package csd_pkg;
   localparam int CSD_NUM_CS = 4;
   localparam int CSD_AW = 24;
   localparam int CSD_NUM_REQ = 4;
   // Byte addresses of the registers on the AHB-Lite slave
   localparam logic [11:0] CSD_OFF_BASE = 12'h0F2;
   localparam logic [11:0] CSD_OFF_CSBASE0 = 12'h100;
   localparam logic [11:0] CSD_OFF_CSMASK0 = 12'h120;
   localparam logic [11:0] CSD_OFF_REQFC0 = 12'h140;
   localparam logic [11:0] CSD_OFF_STATUS = 12'h160;
   localparam logic [11:0] CSD_BLOCK_STEP = 12'h004;
   // Reserved window in the low 12 bits of the base-relative address
   localparam logic [11:0] CSD_RSV_LO = 12'h0F0;
   localparam logic [11:0] CSD_RSV_HI = 12'h0FF;
   localparam logic [2:0] CSD_FC_IACK = 3'h7;
   localparam logic [15:0] CSD_BASE_RST = 16'h0000;
   localparam logic [CSD_AW-1:0] CSD_CSBASE_RST = 24'h00_0000;
   localparam logic [CSD_AW-1:0] CSD_CSMASK_RST = 24'h00_0000;
   // Requester indices
   localparam int CSD_REQ_REFRESH = 3;
   typedef enum logic [1:0] {CSD_SZ_BYTE, CSD_SZ_WORD} csd_size_t;
endpackage : csd_pkg

// File: csd_tb_top.sv
// Register and decode tests for the select decoder
module csd_tb_top
   import csd_pkg::*;
   ;
   timeunit 1ns;
   timeprecision 1ps;
   // Pins and bench command
   logic CLK = 1'b0, SRST = 1'b1, HSEL = 1'b0, HWRITE = 1'b0, go = 1'b0, ext = 1'b0;
   logic [1:0] HTRANS = 2'h0, rq = 2'h0, ACC_REQ;
   logic [2:0] HSIZE = 3'h2, fc = 3'h0, ACCESS_SPACE_CODE, REQ_SPACE_CODE;
   logic [31:0] HADDR = 32'h0000_0000, HWDATA = 32'h0000_0000, HRDATA, r;
   logic [23:0] ad = 24'h00_0000, ACC_ADDR;
   logic [3:0] CS_N;
   logic HREADYOUT, HRESP, IACK_CYCLE, REQ_BYTE_READ, ACC_VALID, ACC_EXTERNAL, AUTOVECTOR_REQUEST_N;
   wire logic HREADY = HREADYOUT;
   int n_fail = 0, cmp_count = 0;
   // Programming; cs1 mask has a hole so it repeats
   logic [23:0] cb [4] = '{24'h10_0000, 24'h20_0000, 24'hFF_FFFF, 24'hFF_FFFF};
   logic [23:0] cm [4] = '{24'hF0_0000, 24'hF0_F000, 24'hFF_FFFF, 24'hFF_FFFF};
   logic [2:0] rc [4] = '{3'h2, 3'h7, 3'h5, 3'h1};
   logic [15:0] bs = 16'h0100;
   csd_top dut_u (.*);
   csd_acc_drv drv_u (.*);
   always #5 CLK = ~CLK;
   task automatic close_out;
      if (n_fail == 0 && cmp_count > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask : close_out
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      cmp_count++;
      if (got !== exp) begin
         n_fail++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk
   // One AHB-Lite single word; waits on ready, no cycle count assumed
   task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] d, output logic [31:0] q);
      HSEL <= 1'b1;
      HADDR <= a;
      HWRITE <= w;
      HTRANS <= 2'h2;
      @(posedge CLK);
      while (!HREADYOUT) @(posedge CLK);
      HTRANS <= 2'h0;
      HWDATA <= d;
      @(posedge CLK);
      while (!HREADYOUT) @(posedge CLK);
      q = HRDATA;
   endtask : bus
   // Expected {code, iack, byte read, selects} from the programmed tables
   function automatic logic [8:0] ex(logic e, logic [1:0] q, logic [23:0] a, logic [2:0] f);
      logic [2:0] c;
      logic [3:0] s;
      c = e ? f : rc[q];
      s = 4'hF;
      for (int i = 0; i < 4; i++)
         if (((a ^ cb[i]) & cm[i]) == 0 && c != 3'h7 && !(a[23:12] == bs[11:0] && a[11:4] == 8'h0F)) s[i] = 1'b0;
      return {c, e && f == 3'h7, !e && q == 2'h3, s};
   endfunction : ex
   // One access through the far side, result one edge after it lands
   task automatic dec(input logic e, input logic [1:0] q, input logic [23:0] a, input logic [2:0] f);
      go <= 1'b1;
      ext <= e;
      rq <= q;
      ad <= a;
      fc <= f;
      @(posedge CLK);
      go <= 1'b0;
      @(posedge CLK);
      #1 chk({23'h0, REQ_SPACE_CODE, IACK_CYCLE, REQ_BYTE_READ, CS_N}, {23'h0, ex(e, q, a, f)});
   endtask : dec
   // Watchdog, far beyond the 78 cycles needed
   initial begin
      repeat (3000) @(posedge CLK);
      n_fail++;
      close_out;
   end
   // Main sequence
   initial begin
      repeat (12) @(posedge CLK);
      SRST <= 1'b0;
      bus(1'b0, 32'h0000_00F0, 32'h0000_0000, r);
      chk(r, 32'h0000_0000);
      bus(1'b1, 32'h0000_0400, 32'hFFFF_FFFF, r);
      bus(1'b0, 32'h0000_0400, 32'h0000_0000, r);
      chk(r, 32'h0000_0000);
      for (int k = 0; k < 4; k++) begin
         bus(1'b1, {20'h0, CSD_OFF_CSBASE0 + 12'(k) * CSD_BLOCK_STEP}, {8'h0, cb[k]}, r);
         bus(1'b1, {20'h0, CSD_OFF_CSMASK0 + 12'(k) * CSD_BLOCK_STEP}, {8'h0, cm[k]}, r);
         bus(1'b1, {20'h0, CSD_OFF_REQFC0 + 12'(k) * CSD_BLOCK_STEP}, {29'h0, rc[k]}, r);
         bus(1'b0, {20'h0, CSD_OFF_REQFC0 + 12'(k) * CSD_BLOCK_STEP}, 32'h0000_0000, r);
         chk(r, {29'h0, rc[k]});
      end
      bus(1'b1, 32'h0000_00F0, {16'h0, bs}, r);
      bus(1'b0, 32'h0000_00F0, 32'h0000_0000, r);
      chk(r, {16'h0, bs});
      dec(1'b1, 2'h0, 24'h10_0000, 3'h5);
      dec(1'b1, 2'h0, 24'h10_0000, 3'h7);
      dec(1'b1, 2'h0, 24'h10_00F8, 3'h5);
      dec(1'b1, 2'h0, 24'h10_00EF, 3'h5);
      dec(1'b1, 2'h0, 24'h10_10F8, 3'h5);
      dec(1'b1, 2'h0, 24'h2A_0123, 3'h2);
      dec(1'b1, 2'h0, 24'h2A_1123, 3'h2);
      dec(1'b1, 2'h0, 24'h5A_0000, 3'h1);
      for (int q = 0; q < 4; q++) dec(1'b0, 2'(q), 24'h10_0004, 3'h0);
      close_out;
   end
endmodule : csd_tb_top

// File: csd_top.sv
// Chip-select decode with on-chip base register and AHB-Lite slave
module csd_top
   import csd_pkg::*;
(
   // Clock and reset
   input wire logic CLK,
   input wire logic SRST,
   // AHB-Lite slave
   input wire logic HSEL,
   input wire logic [31:0] HADDR,
   input wire logic [1:0] HTRANS,
   input wire logic HWRITE,
   input wire logic [2:0] HSIZE,
   input wire logic [31:0] HWDATA,
   input wire logic HREADY,
   output logic [31:0] HRDATA,
   output logic HREADYOUT,
   output logic HRESP,
   // Access to decode
   input wire logic ACC_VALID,
   input wire logic [CSD_AW-1:0] ACC_ADDR,
   input wire logic [2:0] ACCESS_SPACE_CODE,
   input wire logic ACC_EXTERNAL,
   input wire logic [1:0] ACC_REQ,
   // Autovector request from external logic, active low
   input wire logic AUTOVECTOR_REQUEST_N,
   // Decode results
   output logic [CSD_NUM_CS-1:0] CS_N,
   output logic IACK_CYCLE,
   output logic [2:0] REQ_SPACE_CODE,
   output logic REQ_BYTE_READ
);
   typedef struct packed {
      logic [15:0] base_reg;
      logic [CSD_NUM_CS-1:0][CSD_AW-1:0] csbase_reg;
      logic [CSD_NUM_CS-1:0][CSD_AW-1:0] csmask_reg;
      logic [CSD_NUM_REQ-1:0][2:0] reqfc_reg;
      logic wr_pend_reg;
      logic [11:0] wr_addr_reg;
      logic [31:0] rdata_reg;
      logic [CSD_NUM_CS-1:0] cs_n_reg;
      logic iack_reg;
      logic [2:0] req_fc_reg;
      logic byte_rd_reg;
      logic autovec_seen_reg;
   } csd_state_t;

   csd_state_t st_reg;
   csd_state_t st_next;
   logic [CSD_NUM_CS-1:0] hit;
   logic [2:0] eff_fc;
   logic in_rsv;
   logic take;

   // One comparator per select
   genvar g;
   generate
      for (g = 0; g < CSD_NUM_CS; g++) begin : g_cs
         csd_match u_match (
            .base(st_reg.csbase_reg[g]),
            .mask(st_reg.csmask_reg[g]),
            .addr(ACC_ADDR),
            .hit(hit[g])
         );
      end
   endgenerate

   // Register index of a bank of word registers, or -1 when outside it
   function automatic int bank_idx(input logic [11:0] a, input logic [11:0] first, input int n);
      int k;
      bank_idx = -1;
      for (k = 0; k < n; k++) begin
         if (a == first + 12'(k) * CSD_BLOCK_STEP) begin
            bank_idx = k;
         end
      end
   endfunction : bank_idx

   // Word address of the base register; a 16-bit value in the low half
   function automatic logic is_base(input logic [11:0] a);
      is_base = {a[11:2], 2'b00} == {CSD_OFF_BASE[11:2], 2'b00};
   endfunction : is_base

   // Access qualification
   always_comb begin
      // Requesters take their code from their own register, externals from the pins
      eff_fc = ACC_EXTERNAL ? ACCESS_SPACE_CODE : st_reg.reqfc_reg[ACC_REQ]; // [R02] [R08]
      // Window is relative to the on-chip base: upper 12 address bits must equal its low 12 bits
      in_rsv = (ACC_ADDR[CSD_AW-1:12] == st_reg.base_reg[CSD_AW-13:0])
         && (ACC_ADDR[11:0] >= CSD_RSV_LO) && (ACC_ADDR[11:0] <= CSD_RSV_HI); // [R05]
   end

   assign take = HSEL && HREADY && HTRANS[1];

   always_comb begin
      int i;
      i = 0;
      st_next = st_reg;
      // Decode: a select needs a match and a code other than 111
      st_next.iack_reg = ACC_VALID && ACC_EXTERNAL && (ACCESS_SPACE_CODE == CSD_FC_IACK); // [R03] [R04]
      for (i = 0; i < CSD_NUM_CS; i++) begin
         st_next.cs_n_reg[i] = !(ACC_VALID && hit[i] && !in_rsv && (eff_fc != CSD_FC_IACK)); // [R10] [R02] [R03]
      end
      st_next.req_fc_reg = eff_fc;
      // Refresh cycles are byte reads only
      st_next.byte_rd_reg = ACC_VALID && !ACC_EXTERNAL && (ACC_REQ == 2'(CSD_REQ_REFRESH)); // [R07]
      // Autovector only counts during an acknowledge cycle; it stands in for the acknowledge
      st_next.autovec_seen_reg = st_next.iack_reg && !AUTOVECTOR_REQUEST_N; // [R09]
      // Write data phase
      st_next.wr_pend_reg = take && HWRITE;
      if (take) begin
         st_next.wr_addr_reg = HADDR[11:0];
      end
      if (st_reg.wr_pend_reg) begin
         // Base register lives here, so only a bus write or reset changes it
         if (is_base(st_reg.wr_addr_reg)) begin
            st_next.base_reg = HWDATA[15:0]; // [R06]
         end
         i = bank_idx(st_reg.wr_addr_reg, CSD_OFF_CSBASE0, CSD_NUM_CS);
         if (i >= 0) begin
            st_next.csbase_reg[i] = HWDATA[CSD_AW-1:0];
         end
         i = bank_idx(st_reg.wr_addr_reg, CSD_OFF_CSMASK0, CSD_NUM_CS);
         if (i >= 0) begin
            st_next.csmask_reg[i] = HWDATA[CSD_AW-1:0];
         end
         i = bank_idx(st_reg.wr_addr_reg, CSD_OFF_REQFC0, CSD_NUM_REQ);
         if (i >= 0) begin
            st_next.reqfc_reg[i] = HWDATA[2:0]; // [R08]
         end
      end
      // Read data is captured at the address phase; unmapped reads give zero
      if (take && !HWRITE) begin
         st_next.rdata_reg = 32'h0000_0000;
         if (is_base(HADDR[11:0])) begin
            st_next.rdata_reg = {16'h0000, st_reg.base_reg};
         end
         if (HADDR[11:0] == CSD_OFF_STATUS) begin
            st_next.rdata_reg = {24'h00_0000, st_reg.autovec_seen_reg, st_reg.iack_reg,
               st_reg.byte_rd_reg, 1'b0, st_reg.cs_n_reg};
         end
         i = bank_idx(HADDR[11:0], CSD_OFF_CSBASE0, CSD_NUM_CS);
         if (i >= 0) begin
            st_next.rdata_reg = {8'h00, st_reg.csbase_reg[i]};
         end
         i = bank_idx(HADDR[11:0], CSD_OFF_CSMASK0, CSD_NUM_CS);
         if (i >= 0) begin
            st_next.rdata_reg = {8'h00, st_reg.csmask_reg[i]};
         end
         i = bank_idx(HADDR[11:0], CSD_OFF_REQFC0, CSD_NUM_REQ);
         if (i >= 0) begin
            st_next.rdata_reg = {29'h0000_0000, st_reg.reqfc_reg[i]};
         end
      end
   end

   // State register; requester codes keep whatever they hold, as in the RAM
   always_ff @(posedge CLK) begin
      if (SRST) begin
         st_reg.base_reg <= CSD_BASE_RST;
         st_reg.csbase_reg <= '0;
         st_reg.csmask_reg <= '0;
         st_reg.wr_pend_reg <= 1'b0;
         st_reg.wr_addr_reg <= 12'h000;
         st_reg.rdata_reg <= 32'h0000_0000;
         st_reg.cs_n_reg <= '1;
         st_reg.iack_reg <= 1'b0;
         st_reg.req_fc_reg <= 3'h0;
         st_reg.byte_rd_reg <= 1'b0;
         st_reg.autovec_seen_reg <= 1'b0;
         st_reg.reqfc_reg <= st_next.reqfc_reg; // [R08]
      end else begin
         st_reg <= st_next;
      end
   end

   // Data and decode outputs straight from flip-flops; slave never waits, ready and response tied off
   assign HRDATA = st_reg.rdata_reg;
   assign HREADYOUT = 1'b1;
   assign HRESP = 1'b0;
   assign CS_N = st_reg.cs_n_reg;
   assign IACK_CYCLE = st_reg.iack_reg;
   assign REQ_SPACE_CODE = st_reg.req_fc_reg;
   assign REQ_BYTE_READ = st_reg.byte_rd_reg;
endmodule : csd_top
